// ---- common/syn_pkg.sv ----
// Purpose: Constants and types shared by the synthesizer control block.
// Assumes: 32-bit shift register; word type decoded from its last bits.
// Notes: Field positions below define the serial word layout.
// Summary of operation
// - Hold modulus 64, 65, 72 cycle counts
// - Prescaler type 01 two-modulus, 10 three-modulus
// - Fractional accumulator modulo 8 or 5
// - Format flag picks short or long A word
// - Keep 8-bit main pump current factor
// - Keep 2-bit proportional acceleration factor
// - Keep 4-bit integral acceleration factor
// - Separate main and auxiliary divider enables
// - 2-bit reference tap select, main detector
// - 2-bit reference tap select, auxiliary detector
// - Auxiliary predivide by 4 or by 1
// - Compensation on one reference cycle around pulse
// - Shift data on clock rise while latch low
// - Add increment each cycle; overflow flag clears before modulus 64, so ratio stays fixed
// - New A word loads at modulus-64 terminal, or at once while the main divider is disabled
package syn_pkg;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 4;
  localparam int NM1_W = 12;
  localparam int NM2_W = 8;
  localparam int NM3_W = 4;
  localparam int NF_W = 3;
  localparam int CN_W = 8;
  localparam int CL_W = 2;
  localparam int CK_W = 4;
  localparam int SEL_W = 2;
  localparam int RATIO_W = 12;
  localparam int ACC_W = 4;
  // Word kinds: last bit 0 is an A word, else a 4-bit address
  localparam logic [ADDR_W-1:0] ADDR_B = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_C = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_D = 4'h5;
  localparam int A0_NM1_LSB = 12;
  localparam int A0_NM2_LSB = 4;
  localparam int A0_NF_LSB = 1;
  localparam int A1_NM1_LSB = 20;
  localparam int A1_NM2_LSB = 12;
  localparam int A1_NF_LSB = 9;
  localparam int A1_CN_LSB = 1;
  localparam int B_CN_LSB = 24;
  localparam int B_PR_LSB = 22;
  localparam int B_CL_LSB = 20;
  localparam int B_CK_LSB = 16;
  localparam int B_FRAC_MODULUS_SEL_BIT = 15;
  localparam int C_NR_LSB = 20;
  localparam int C_SM_LSB = 18;
  localparam int C_SA_LSB = 16;
  localparam int C_EM_BIT = 15;
  localparam int C_EA_BIT = 14;
  localparam int D_NA_LSB = 20;
  localparam int D_PA_BIT = 19;
  localparam int D_LONG_BIT = 18;
  localparam logic [1:0] PR_TWO = 2'h1;
  localparam logic [1:0] PR_THREE = 2'h2;
  localparam logic [ACC_W-1:0] FRAC_Q_EIGHT = 4'h8;
  localparam logic [ACC_W-1:0] FRAC_Q_FIVE = 4'h5;
  localparam logic [1:0] AUX_PREDIV_LAST = 2'h3;
  localparam logic [1:0] MOD_64 = 2'h0;
  localparam logic [1:0] MOD_65 = 2'h1;
  localparam logic [1:0] MOD_72 = 2'h2;
  localparam logic [RATIO_W-1:0] RATIO_RST = 12'h004;
  localparam logic [RATIO_W-1:0] CNT_LAST = 12'h001;
  localparam logic [RATIO_W-1:0] CNT_PRE = 12'h002;
  typedef enum logic [1:0] {PH_M65, PH_M72, PH_M64} syn_phase_t;
  typedef enum logic [1:0] {COMP_OFF, COMP_ON, COMP_TAIL} syn_comp_t;
endpackage : syn_pkg

// ---- common/syn_word_if.sv ----
// Purpose: Carries received serial words from the port to the core.
// Assumes: All signals are on sys_clk.
// Notes: word is valid in the cycle word_stb is high.
interface syn_word_if;
  logic [31:0] word;
  logic word_stb;
  logic strobe_hi;
  modport rx (output word, output word_stb, output strobe_hi);
  modport core (input word, input word_stb, input strobe_hi);
endinterface : syn_word_if

// ---- rtl/syn_serial_rx.sv ----
// Purpose: Three-wire serial receiver with transfer into sys_clk.
// Assumes: Latch strobe stays high long enough for three sys_clk edges.
// Notes: Shift register is quiet while strobe is high, so it is copied.
module syn_serial_rx import syn_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_strobe,
  syn_word_if.rx wif
);
  // ****************************************
  // Link domain shift register
  // ****************************************
  logic [WORD_W-1:0] shreg;
  logic [WORD_W-1:0] next_shreg;

  always_comb begin
    next_shreg = shreg;
    if (!ser_strobe) begin
      next_shreg = {shreg[WORD_W-2:0], ser_data};
    end
  end

  always_ff @(posedge ser_clk) begin
    shreg <= next_shreg;
  end

  // ****************************************
  // Strobe crossing and word capture
  // ****************************************
  logic strb_s1, strb_s2, strb_s3;
  logic next_strb_s1, next_strb_s2, next_strb_s3;
  logic [WORD_W-1:0] word_q, next_word_q;
  logic stb_q, next_stb_q;

  always_comb begin
    next_strb_s1 = ser_strobe;
    next_strb_s2 = strb_s1;
    next_strb_s3 = strb_s2;
    next_stb_q = strb_s2 & ~strb_s3;
    next_word_q = word_q;
    // Safe copy: shift register holds its value while strobe is high
    if (strb_s2 && !strb_s3) begin
      next_word_q = shreg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      strb_s1 <= 1'b1;
      strb_s2 <= 1'b1;
      strb_s3 <= 1'b1;
      stb_q <= 1'b0;
      word_q <= '0;
    end else begin
      strb_s1 <= next_strb_s1;
      strb_s2 <= next_strb_s2;
      strb_s3 <= next_strb_s3;
      stb_q <= next_stb_q;
      word_q <= next_word_q;
    end
  end

  assign wif.word = word_q;
  assign wif.word_stb = stb_q;
  assign wif.strobe_hi = strb_s2;
endmodule : syn_serial_rx

// ---- rtl/syn_ref_div.sv ----
// Purpose: Reference divider with binary tap counter and tap selects.
// Assumes: ratio kept in 4..4095 by the host.
// Notes: Tap k pulses every 2**k terminal counts of the ratio counter.
module syn_ref_div import syn_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ref_in,
  input wire logic run,
  input wire logic [RATIO_W-1:0] ratio,
  input wire logic [SEL_W-1:0] main_sel,
  input wire logic [SEL_W-1:0] aux_sel,
  output logic ref_edge,
  output logic main_ref_pulse,
  output logic main_ref_pre,
  output logic aux_ref_pulse
);
  logic ref_s1, ref_s2, ref_s3;
  logic [RATIO_W-1:0] cnt, next_cnt;
  logic [2:0] bin, next_bin;
  logic [3:0] tap;
  logic next_edge, next_main, next_pre, next_aux;

  // Tap k fires when the low k bits of the binary counter are all ones
  generate
    for (genvar k = 0; k < 4; k++) begin : g_tap
      if (k == 0) begin : g_z
        assign tap[k] = 1'b1;
      end else begin : g_n
        assign tap[k] = &bin[k-1:0];
      end
    end
  endgenerate

  always_comb begin
    next_edge = ref_s2 & ~ref_s3;
    next_cnt = cnt;
    next_bin = bin;
    next_main = 1'b0;
    next_aux = 1'b0;
    next_pre = 1'b0;
    if (!run) begin
      next_cnt = ratio;
      next_bin = '0;
    end else if (next_edge) begin
      if (cnt <= CNT_LAST) begin
        next_cnt = ratio;
        next_bin = bin + 3'h1;
        next_main = tap[main_sel];
        next_aux = tap[aux_sel];
      end else begin
        next_cnt = cnt - CNT_LAST;
        // One reference cycle ahead of the selected tap
        next_pre = (cnt == CNT_PRE) && tap[main_sel];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      cnt <= RATIO_RST;
      bin <= '0;
      ref_edge <= 1'b0;
      main_ref_pulse <= 1'b0;
      main_ref_pre <= 1'b0;
      aux_ref_pulse <= 1'b0;
    end else begin
      ref_s1 <= ref_in;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      cnt <= next_cnt;
      bin <= next_bin;
      ref_edge <= next_edge;
      main_ref_pulse <= next_main;
      main_ref_pre <= next_pre;
      aux_ref_pulse <= next_aux;
    end
  end
endmodule : syn_ref_div

// ---- rtl/syn_synth_ctrl.sv ----
// Purpose: Control fields, main and auxiliary dividers of a synthesizer.
// Assumes: Prescaler, reference and auxiliary inputs are slow pin levels.
// Notes: Configuration arrives only through the three-wire port.
module syn_synth_ctrl import syn_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_strobe,
  input wire logic prescaler_in,
  input wire logic ref_in,
  input wire logic aux_in,
  output logic [NM1_W-1:0] main_cnt_mod64,
  output logic [NM2_W-1:0] main_cnt_mod65,
  output logic [NM3_W-1:0] main_cnt_mod72,
  output logic [1:0] prescaler_type,
  output logic [NF_W-1:0] frac_increment,
  output logic frac_modulus_sel,
  output logic long_a_word,
  output logic [CN_W-1:0] pump_current_factor,
  output logic [CL_W-1:0] prop_accel_factor,
  output logic [CK_W-1:0] integ_accel_factor,
  output logic main_div_enable,
  output logic aux_div_enable,
  output logic [SEL_W-1:0] main_ref_select,
  output logic [SEL_W-1:0] aux_ref_select,
  output logic [RATIO_W-1:0] ref_div_ratio,
  output logic [RATIO_W-1:0] aux_div_ratio,
  output logic aux_prediv_mode,
  output logic [1:0] prescaler_modulus,
  output logic main_div_pulse,
  output logic main_ref_pulse,
  output logic aux_ref_pulse,
  output logic aux_div_pulse,
  output logic comp_current_on,
  output logic speed_up,
  output logic [NF_W-1:0] frac_accum_value
);
  // ****************************************
  // Serial port and reference divider
  // ****************************************
  syn_word_if wif ();
  logic ref_edge, ref_pre;

  syn_serial_rx u_rx (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_strobe(ser_strobe),
    .wif(wif.rx)
  );

  syn_ref_div u_ref (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ref_in(ref_in),
    .run(main_div_enable | aux_div_enable),
    .ratio(ref_div_ratio),
    .main_sel(main_ref_select),
    .aux_sel(aux_ref_select),
    .ref_edge(ref_edge),
    .main_ref_pulse(main_ref_pulse),
    .main_ref_pre(ref_pre),
    .aux_ref_pulse(aux_ref_pulse)
  );

  // ****************************************
  // Word decode and configuration fields
  // ****************************************
  function automatic logic is_addr(input logic [WORD_W-1:0] w,
                                   input logic [ADDR_W-1:0] a);
    is_addr = w[0] && (w[ADDR_W-1:0] == a);
  endfunction : is_addr

  logic [WORD_W-1:0] w;
  logic a_word;
  logic [CN_W-1:0] cn_tmp, next_cn_tmp;
  logic [1:0] pr_tmp, next_pr_tmp;
  logic pend, next_pend;
  logic [NM1_W-1:0] p_nm1, next_p_nm1;
  logic [NM2_W-1:0] p_nm2, next_p_nm2;
  logic [NF_W-1:0] p_nf, next_p_nf;
  logic [CN_W-1:0] p_cn, next_p_cn;
  logic [1:0] p_pr, next_p_pr;
  logic [CL_W-1:0] next_cl;
  logic [CK_W-1:0] next_ck;
  logic next_frac_modulus_sel, next_long, next_em, next_ea, next_pa;
  logic [SEL_W-1:0] next_sm, next_sa;
  logic [RATIO_W-1:0] next_nr, next_na;
  logic next_speed;
  logic load_work;

  assign w = wif.word;
  assign a_word = wif.word_stb && !w[0];

  always_comb begin
    next_cn_tmp = cn_tmp;
    next_pr_tmp = pr_tmp;
    next_cl = prop_accel_factor;
    next_ck = integ_accel_factor;
    next_frac_modulus_sel = frac_modulus_sel;
    next_long = long_a_word;
    next_em = main_div_enable;
    next_ea = aux_div_enable;
    next_pa = aux_prediv_mode;
    next_sm = main_ref_select;
    next_sa = aux_ref_select;
    next_nr = ref_div_ratio;
    next_na = aux_div_ratio;
    next_pend = pend && !load_work;
    next_p_nm1 = p_nm1;
    next_p_nm2 = p_nm2;
    next_p_nf = p_nf;
    next_p_cn = p_cn;
    next_p_pr = p_pr;
    // Speed-up holds while the latch strobe stays high
    next_speed = a_word | (speed_up & wif.strobe_hi);
    if (wif.word_stb && is_addr(w, ADDR_B)) begin
      next_cn_tmp = w[B_CN_LSB +: CN_W];
      next_pr_tmp = w[B_PR_LSB +: 2];
      next_cl = w[B_CL_LSB +: CL_W];
      next_ck = w[B_CK_LSB +: CK_W];
      next_frac_modulus_sel = w[B_FRAC_MODULUS_SEL_BIT];
    end
    if (wif.word_stb && is_addr(w, ADDR_C)) begin
      next_nr = w[C_NR_LSB +: RATIO_W];
      next_sm = w[C_SM_LSB +: SEL_W];
      next_sa = w[C_SA_LSB +: SEL_W];
      next_em = w[C_EM_BIT];
      next_ea = w[C_EA_BIT];
    end
    if (wif.word_stb && is_addr(w, ADDR_D)) begin
      next_na = w[D_NA_LSB +: RATIO_W];
      next_pa = w[D_PA_BIT];
      next_long = w[D_LONG_BIT];
    end
    if (a_word) begin
      next_pend = 1'b1;
      next_p_pr = pr_tmp;
      if (long_a_word) begin
        next_p_nm1 = w[A1_NM1_LSB +: NM1_W];
        next_p_nm2 = w[A1_NM2_LSB +: NM2_W];
        next_p_nf = w[A1_NF_LSB +: NF_W];
        next_p_cn = w[A1_CN_LSB +: CN_W];
      end else begin
        next_p_nm1 = w[A0_NM1_LSB +: NM1_W];
        next_p_nm2 = w[A0_NM2_LSB +: NM2_W];
        next_p_nf = w[A0_NF_LSB +: NF_W];
        next_p_cn = cn_tmp;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cn_tmp <= '0;
      pr_tmp <= PR_TWO;
      prop_accel_factor <= '0;
      integ_accel_factor <= '0;
      frac_modulus_sel <= 1'b0;
      long_a_word <= 1'b0;
      main_div_enable <= 1'b0;
      aux_div_enable <= 1'b0;
      aux_prediv_mode <= 1'b0;
      main_ref_select <= '0;
      aux_ref_select <= '0;
      ref_div_ratio <= RATIO_RST;
      aux_div_ratio <= RATIO_RST;
      pend <= 1'b0;
      p_nm1 <= '0;
      p_nm2 <= '0;
      p_nf <= '0;
      p_cn <= '0;
      p_pr <= PR_TWO;
      speed_up <= 1'b0;
    end else begin
      cn_tmp <= next_cn_tmp;
      pr_tmp <= next_pr_tmp;
      prop_accel_factor <= next_cl;
      integ_accel_factor <= next_ck;
      frac_modulus_sel <= next_frac_modulus_sel;
      long_a_word <= next_long;
      main_div_enable <= next_em;
      aux_div_enable <= next_ea;
      aux_prediv_mode <= next_pa;
      main_ref_select <= next_sm;
      aux_ref_select <= next_sa;
      ref_div_ratio <= next_nr;
      aux_div_ratio <= next_na;
      pend <= next_pend;
      p_nm1 <= next_p_nm1;
      p_nm2 <= next_p_nm2;
      p_nf <= next_p_nf;
      p_cn <= next_p_cn;
      p_pr <= next_p_pr;
      speed_up <= next_speed;
    end
  end

  // ****************************************
  // Main divider and fractional accumulator
  // ****************************************
  logic pre_s1, pre_s2, pre_s3, pre_edge;
  syn_phase_t phase, next_phase;
  logic [NM1_W-1:0] cnt, next_cnt;
  logic ovf, next_ovf;
  logic [ACC_W-1:0] acc_sum, acc_q;
  logic [NF_W-1:0] next_acc;
  logic [1:0] next_mod;
  logic next_mpulse;
  logic [NM1_W-1:0] next_nm1;
  logic [NM2_W-1:0] next_nm2;
  logic [NF_W-1:0] next_nf;
  logic [CN_W-1:0] next_cn;
  logic [1:0] next_pr;
  logic terminal;

  assign pre_edge = pre_s2 & ~pre_s3;
  assign terminal = main_div_enable && pre_edge && (phase == PH_M64)
                    && (cnt == '0);
  // Disabled divider has no phase to protect, so load at once
  assign load_work = pend && (terminal || !main_div_enable);
  assign acc_q = frac_modulus_sel ? FRAC_Q_EIGHT : FRAC_Q_FIVE;
  assign acc_sum = {1'b0, frac_accum_value} + {1'b0, frac_increment};
  // Three-modulus type splits the mod-65 field into two nibbles
  assign main_cnt_mod72 = (prescaler_type == PR_THREE) ?
                          main_cnt_mod65[NM2_W-1:NM3_W] : '0;

  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_ovf = ovf;
    next_acc = frac_accum_value;
    next_mpulse = 1'b0;
    next_nm1 = load_work ? p_nm1 : main_cnt_mod64;
    next_nm2 = load_work ? p_nm2 : main_cnt_mod65;
    next_nf = load_work ? p_nf : frac_increment;
    next_cn = load_work ? p_cn : pump_current_factor;
    next_pr = load_work ? p_pr : prescaler_type;
    if (!main_div_enable) begin
      next_phase = PH_M65;
      next_cnt = '0;
      next_ovf = 1'b0;
    end else if (pre_edge) begin
      next_ovf = 1'b0;
      next_cnt = cnt - 12'h001;
      case (phase)
        PH_M65: begin
          if (cnt == '0) begin
            next_phase = (prescaler_type == PR_THREE) ? PH_M72 : PH_M64;
            next_cnt = (prescaler_type == PR_THREE) ?
                       {8'h00, main_cnt_mod72} : main_cnt_mod64;
          end
        end
        PH_M72: begin
          if (cnt == '0) begin
            next_phase = PH_M64;
            next_cnt = main_cnt_mod64;
          end
        end
        PH_M64: begin
          if (cnt == '0) begin
            next_mpulse = 1'b1;
            next_phase = PH_M65;
            next_cnt = (next_pr == PR_THREE) ?
                       {8'h00, next_nm2[NM3_W-1:0]} :
                       {4'h0, next_nm2};
            // Overflow flag clears at the next prescaler edge, before PH_M64 can use it
            if (acc_sum >= acc_q) begin
              next_acc = NF_W'(acc_sum - acc_q);
              next_ovf = 1'b1;
            end else begin
              next_acc = NF_W'(acc_sum);
            end
          end
        end
        default: begin
          next_phase = PH_M65;
        end
      endcase
    end
    case (next_phase)
      PH_M72: next_mod = MOD_72;
      PH_M64: next_mod = next_ovf ? MOD_65 : MOD_64;
      default: next_mod = MOD_65;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pre_s1 <= 1'b0;
      pre_s2 <= 1'b0;
      pre_s3 <= 1'b0;
      phase <= PH_M65;
      cnt <= '0;
      ovf <= 1'b0;
      frac_accum_value <= '0;
      prescaler_modulus <= MOD_65;
      main_div_pulse <= 1'b0;
      main_cnt_mod64 <= '0;
      main_cnt_mod65 <= '0;
      frac_increment <= '0;
      pump_current_factor <= '0;
      prescaler_type <= PR_TWO;
    end else begin
      pre_s1 <= prescaler_in;
      pre_s2 <= pre_s1;
      pre_s3 <= pre_s2;
      phase <= next_phase;
      cnt <= next_cnt;
      ovf <= next_ovf;
      frac_accum_value <= next_acc;
      prescaler_modulus <= next_mod;
      main_div_pulse <= next_mpulse;
      main_cnt_mod64 <= next_nm1;
      main_cnt_mod65 <= next_nm2;
      frac_increment <= next_nf;
      pump_current_factor <= next_cn;
      prescaler_type <= next_pr;
    end
  end

  // ****************************************
  // Auxiliary divider and compensation window
  // ****************************************
  logic aux_s1, aux_s2, aux_s3, aux_edge, aux_tick;
  logic [1:0] pdiv, next_pdiv;
  logic [RATIO_W-1:0] acnt, next_acnt;
  logic next_apulse;
  syn_comp_t comp, next_comp;

  assign aux_edge = aux_s2 & ~aux_s3;
  assign aux_tick = aux_edge &&
                    (aux_prediv_mode || pdiv == AUX_PREDIV_LAST);

  always_comb begin
    next_pdiv = pdiv;
    next_acnt = acnt;
    next_apulse = 1'b0;
    if (!aux_div_enable) begin
      next_pdiv = '0;
      next_acnt = aux_div_ratio;
    end else begin
      if (aux_edge) begin
        next_pdiv = pdiv + 2'h1;
      end
      if (aux_tick) begin
        if (acnt <= CNT_LAST) begin
          next_acnt = aux_div_ratio;
          next_apulse = 1'b1;
        end else begin
          next_acnt = acnt - CNT_LAST;
        end
      end
    end
    next_comp = comp;
    case (comp)
      COMP_OFF: if (ref_pre && main_div_enable) next_comp = COMP_ON;
      COMP_ON: if (next_mpulse) next_comp = COMP_TAIL;
      COMP_TAIL: if (ref_edge) next_comp = COMP_OFF;
      default: next_comp = COMP_OFF;
    endcase
    if (!main_div_enable) begin
      next_comp = COMP_OFF;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      aux_s1 <= 1'b0;
      aux_s2 <= 1'b0;
      aux_s3 <= 1'b0;
      pdiv <= '0;
      acnt <= RATIO_RST;
      aux_div_pulse <= 1'b0;
      comp <= COMP_OFF;
      comp_current_on <= 1'b0;
    end else begin
      aux_s1 <= aux_in;
      aux_s2 <= aux_s1;
      aux_s3 <= aux_s2;
      pdiv <= next_pdiv;
      acnt <= next_acnt;
      aux_div_pulse <= next_apulse;
      comp <= next_comp;
      comp_current_on <= (next_comp != COMP_OFF);
    end
  end
endmodule : syn_synth_ctrl

// ---- verification/syn_synth_ctrl_asserts.sv ----
// Purpose: Port-level assertions for the synthesizer control block.
// Assumes: One sys_clk domain; strobe is a slow level seen on sys_clk.
// Notes: Bound to every instance of the control block.
module syn_synth_ctrl_asserts import syn_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ser_strobe,
  input wire logic [NM2_W-1:0] main_cnt_mod65,
  input wire logic [NM3_W-1:0] main_cnt_mod72,
  input wire logic [1:0] prescaler_type,
  input wire logic [1:0] prescaler_modulus,
  input wire logic [RATIO_W-1:0] ref_div_ratio,
  input wire logic [RATIO_W-1:0] aux_div_ratio,
  input wire logic main_div_enable,
  input wire logic main_div_pulse,
  input wire logic main_ref_pulse,
  input wire logic comp_current_on,
  input wire logic speed_up,
  input wire logic [NF_W-1:0] frac_accum_value
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ****
  // Checks
  // ****
  a_mod72_unused: assert property (
    prescaler_type != PR_THREE |-> main_cnt_mod72 == 4'h0)
    else $error("mod72 count set in two-modulus mode");
  a_mod72_nibble: assert property (
    prescaler_type == PR_THREE |-> main_cnt_mod72 == main_cnt_mod65[7:4])
    else $error("mod72 count not upper nibble");
  a_modulus_type: assert property (
    prescaler_modulus == MOD_72 |-> prescaler_type == PR_THREE)
    else $error("modulus 72 without three-modulus type");
  a_fields_hold: assert property (
    !ser_strobe [*6] |=> $stable({ref_div_ratio, aux_div_ratio}))
    else $error("field changed with no word latched");
  a_accum_step: assert property (
    !main_div_pulse && !$past(main_div_pulse) |-> $stable(frac_accum_value))
    else $error("accumulator moved without divider completion");
  a_pulse_single: assert property (
    main_div_pulse |=> !main_div_pulse)
    else $error("main divider pulse longer than one cycle");
  a_comp_at_ref: assert property (
    main_ref_pulse && main_div_enable |-> comp_current_on)
    else $error("compensation off at reference pulse");
  a_speed_clear: assert property (
    !ser_strobe [*5] |-> !speed_up)
    else $error("speed-up held with strobe low");
  a_main_off: assert property (
    !main_div_enable [*2] |-> !main_div_pulse)
    else $error("main pulse while divider disabled");
endmodule : syn_synth_ctrl_asserts

bind syn_synth_ctrl syn_synth_ctrl_asserts u_chk (.sys_clk, .nrst,
  .ser_strobe, .main_cnt_mod65, .main_cnt_mod72, .prescaler_type,
  .prescaler_modulus, .ref_div_ratio, .aux_div_ratio, .main_div_enable,
  .main_div_pulse, .main_ref_pulse, .comp_current_on, .speed_up,
  .frac_accum_value);

// ---- verification/syn_host_model.sv ----
// Purpose: Host model driving the three-wire programming port.
// Assumes: Link clock 32 ns, standing low between words.
// Notes: Data line inverts after a word so no stale bit lingers.
module syn_host_model (
  output logic ser_clk,
  output logic ser_data,
  output logic ser_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Word transfer
  // ****
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_strobe = 1'b1;
  end
  task automatic put(input logic b);
    ser_data = b;
    #16 ser_clk = 1'b1;
    #16 ser_clk = 1'b0;
  endtask : put
  task automatic close_word();
    ser_data = ~ser_data;
    #5 ser_strobe = 1'b1;
    #250; // Latch needs three sys_clk edges
  endtask : close_word
  task automatic send(input logic [31:0] w);
    ser_strobe = 1'b0;
    for (int i = 31; i >= 0; i--) put(w[i]);
    close_word();
  endtask : send
  task automatic send_short(input logic [23:0] w);
    ser_strobe = 1'b0;
    for (int i = 23; i >= 0; i--) put(w[i]);
    close_word();
  endtask : send_short
endmodule : syn_host_model

// ---- verification/test_synth_control_word_fields.sv ----
// Purpose: Self-checking bench for the synthesizer control block.
// Assumes: Host model drives the serial port on its own clock.
// Notes: Reference period 8, prescaler and aux period 4 sys_clk cycles.
module test_synth_control_word_fields import syn_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, nrst, ser_clk, ser_data, ser_strobe;
  logic [2:0] ph;
  logic [NM1_W-1:0] main_cnt_mod64;
  logic [NM2_W-1:0] main_cnt_mod65;
  logic [NM3_W-1:0] main_cnt_mod72;
  logic [1:0] prescaler_type;
  logic [NF_W-1:0] frac_increment, frac_accum_value;
  logic frac_modulus_sel, long_a_word, main_div_enable, aux_div_enable;
  logic [CN_W-1:0] pump_current_factor;
  logic [CL_W-1:0] prop_accel_factor;
  logic [CK_W-1:0] integ_accel_factor;
  logic [SEL_W-1:0] main_ref_select, aux_ref_select;
  logic [RATIO_W-1:0] ref_div_ratio, aux_div_ratio;
  logic aux_prediv_mode, main_div_pulse, main_ref_pulse, aux_ref_pulse;
  logic aux_div_pulse;
  int n_errors, checks_done;
  syn_synth_ctrl DUT (.sys_clk, .nrst, .ser_clk, .ser_data, .ser_strobe,
    .prescaler_in(ph[1]), .aux_in(ph[1]), .ref_in(ph[2]),
    .main_cnt_mod64, .main_cnt_mod65, .main_cnt_mod72, .prescaler_type,
    .frac_increment, .frac_modulus_sel, .long_a_word,
    .pump_current_factor, .prop_accel_factor, .integ_accel_factor,
    .main_div_enable, .aux_div_enable, .main_ref_select, .aux_ref_select,
    .ref_div_ratio, .aux_div_ratio, .aux_prediv_mode,
    .prescaler_modulus(), .main_div_pulse, .main_ref_pulse, .aux_ref_pulse,
    .aux_div_pulse, .comp_current_on(), .speed_up(), .frac_accum_value);
  syn_host_model host (.ser_clk, .ser_data, .ser_strobe);
  // ****
  // Helpers
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) ph <= ph + 3'h1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic pulse(input int which);
    case (which)
      0: return main_ref_pulse;
      1: return aux_ref_pulse;
      2: return aux_div_pulse;
      default: return main_div_pulse;
    endcase
  endfunction : pulse
  task automatic wait_pulse(input int which);
    int n;
    n = 0;
    while (pulse(which) !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < 3000, 1'b1);
    @(negedge sys_clk);
  endtask : wait_pulse
  // Two pulses skipped so a reprogrammed count settles first
  task automatic gap(input int which, input int exp);
    int n;
    wait_pulse(which);
    wait_pulse(which);
    n = 1;
    while (pulse(which) !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n, exp);
  endtask : gap
  // ****
  // Scenarios
  // ****
  task automatic t_ref();
    host.send({12'h005, 2'h2, 2'h1, 1'b1, 1'b1, 10'h0, ADDR_C});
    @(negedge sys_clk);
    chk({ref_div_ratio, main_ref_select, aux_ref_select}, 16'h0059);
    chk({main_div_enable, aux_div_enable}, 2'h3);
    gap(0, 160);
    gap(1, 80);
  endtask : t_ref
  task automatic t_aux();
    host.send({12'h003, 1'b1, 1'b0, 14'h0, ADDR_D});
    @(negedge sys_clk);
    chk({aux_div_ratio, aux_prediv_mode, long_a_word}, 14'h000e);
    gap(2, 12);
    host.send({12'h003, 1'b0, 1'b0, 14'h0, ADDR_D});
    gap(2, 48);
    chk(ref_div_ratio, 12'h005);
  endtask : t_aux
  task automatic t_short();
    host.send({8'h5a, PR_THREE, 2'h3, 4'h9, 1'b1, 11'h0, ADDR_B});
    @(negedge sys_clk);
    chk({prop_accel_factor, integ_accel_factor}, 6'h39);
    chk({frac_modulus_sel, pump_current_factor}, 9'h100);
    host.send_short({12'h002, 8'h73, 3'h3, 1'b0});
    gap(3, 60);
    chk({main_cnt_mod64, main_cnt_mod65}, 20'h00273);
    chk(main_cnt_mod72, 4'h7);
    chk({prescaler_type, frac_increment}, 5'h13);
    chk(pump_current_factor, 8'h5a);
  endtask : t_short
  task automatic t_accum(input logic fm, input int q);
    int a;
    host.send({8'h5a, PR_THREE, 2'h3, 4'h9, fm, 11'h0, ADDR_B});
    wait_pulse(3);
    wait_pulse(3);
    @(negedge sys_clk);
    a = frac_accum_value;
    repeat (3) begin
      wait_pulse(3);
      @(negedge sys_clk);
      a = (a + 3) % q;
      chk(frac_accum_value, a);
    end
  endtask : t_accum
  task automatic t_long_off();
    int n;
    host.send({12'h003, 1'b1, 1'b1, 14'h0, ADDR_D});
    host.send({12'h004, 8'h21, 3'h0, 8'hc3, 1'b0});
    gap(3, 40);
    chk({long_a_word, pump_current_factor}, 9'h1c3);
    host.send({12'h005, 2'h2, 2'h1, 1'b0, 1'b1, 10'h0, ADDR_C});
    n = 0;
    repeat (200) begin
      @(negedge sys_clk);
      if (main_div_pulse !== 1'b0) n++;
    end
    chk({main_div_enable, n[7:0]}, 9'h000);
    gap(2, 12);
  endtask : t_long_off
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end
  initial begin
    nrst = 1'b0;
    ph = 3'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk({prescaler_type, ref_div_ratio, aux_div_ratio}, 26'h1004004);
    chk({main_cnt_mod64, pump_current_factor, main_div_enable}, 21'h0);
    t_ref();
    t_aux();
    t_short();
    t_accum(1'b1, 8);
    t_accum(1'b0, 5);
    t_long_off();
    close_out();
  end
endmodule : test_synth_control_word_fields
